// [core/fmwp_pkg.sv]
// constants for the flash mode write protect block
// assumes an 8-bit peripheral store bus with 16-bit addresses
package fmwp_pkg;
    // ==========================================
    // register addresses
    localparam logic [15:0] ADDR_KEY = 16'hffc0;
    localparam logic [15:0] ADDR_STATUS = 16'hffc2;
    localparam logic [15:0] ADDR_MODE = 16'hffc4;
    // ==========================================
    // values and field positions
    localparam logic [7:0] KEY_VALUE = 8'ha5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET_USER = 8'h08;
    localparam logic [7:0] MODE_RESET_ONBOARD = 8'h0c;
    localparam int BIT_ERR = 0;
    localparam int BIT_SEL_LO = 0;
    localparam int BIT_SEL_HI = 1;
    localparam int BIT_PIN = 2;
    localparam int BIT_WDIS = 3;
    localparam logic [1:0] SEL_PROHIBITED = 2'h2;
    // ==========================================
    // boot swap window: two 4 KB clusters
    localparam int CLUSTER_BITS = 12;
    localparam logic [15:0] BOOT_AREA_END = 16'h2000;
    // strap settle: two sync stages plus one load cycle
    localparam logic [1:0] INIT_CYCLES = 2'h3;
    // ==========================================
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_KEYED = 2'b01,
        SEQ_FIRST = 2'b10,
        SEQ_INVERTED = 2'b11
    } fmwp_seq_t;
endpackage : fmwp_pkg

// [core/fmwp_top.sv]
// flash mode control register with keyed unlock, status flag and boot swap
// assumes one store strobe per cycle from the cpu, pins asynchronous
`timescale 1ns/1ns
module fmwp_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // cpu store/load port
    input wire logic i_wr_en,
    input wire logic i_wr_periph,
    input wire logic i_wr_bit,
    input wire logic [2:0] i_wr_bitpos,
    input wire logic [15:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    // pins and firmware side
    input wire logic i_flash_mode_pin,
    input wire logic i_onboard_mode,
    input wire logic i_boot_flag,
    input wire logic [15:0] i_cpu_addr,
    input wire logic [15:0] i_fw_addr,
    output logic [15:0] o_flash_addr,
    output logic o_flash_write_enable,
    output logic [1:0] o_self_prog_mode,
    output logic o_boot_swap
);
    // ==========================================
    // pin synchronisers
    // the pin may move at any time; strap and boot flag are static
    logic [1:0] pin_sync_q;
    logic [1:0] onboard_sync_q;
    logic [1:0] boot_sync_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_sync_q <= 2'h0;
            onboard_sync_q <= 2'h0;
            boot_sync_q <= 2'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[0], i_flash_mode_pin};
            onboard_sync_q <= {onboard_sync_q[0], i_onboard_mode};
            boot_sync_q <= {boot_sync_q[0], i_boot_flag};
        end
    end
    wire logic pin_level = pin_sync_q[1];
    wire logic onboard = onboard_sync_q[1];

    // ==========================================
    // store decode; a bit store merges into the current value
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [1:0] init_cnt_q;
    logic [7:0] mode_view;
    logic [7:0] mode_wdata;
    logic [7:0] status_wdata;
    wire logic init_done = (init_cnt_q == fmwp_pkg::INIT_CYCLES);
    wire logic hit_key = (i_wr_addr == fmwp_pkg::ADDR_KEY);
    wire logic hit_mode = (i_wr_addr == fmwp_pkg::ADDR_MODE);
    wire logic hit_status = (i_wr_addr == fmwp_pkg::ADDR_STATUS);
    // memory stores and stores during strap load never reach the tracker
    wire logic store = i_wr_en & i_wr_periph & init_done;
    wire logic st_key = store & ~i_wr_bit & hit_key;
    wire logic st_mode = store & hit_mode;
    wire logic st_status = store & hit_status;
    // a bit store to the key register is not a valid key access: ignored
    wire logic st_other = store & ~hit_mode & ~hit_key;

    always_comb begin
        mode_view = {4'h0, mode_q[fmwp_pkg::BIT_WDIS], pin_level, mode_q[1:0]};
        mode_wdata = i_wr_data;
        status_wdata = i_wr_data;
        if (i_wr_bit) begin
            mode_wdata = mode_view;
            mode_wdata[i_wr_bitpos] = i_wr_data[0];
            status_wdata = status_q;
            status_wdata[i_wr_bitpos] = i_wr_data[0];
        end
    end

    // ==========================================
    // unlock sequence tracker
    // idle -> keyed on key a5, keyed -> first on the target store,
    // first -> inverted on the exact inverse, inverted -> idle on the
    // repeat; only that last store commits. any slip drops back to idle,
    // so a stray write can never finish a half-done unlock
    fmwp_pkg::fmwp_seq_t seq_q;
    fmwp_pkg::fmwp_seq_t seq_d;
    logic [7:0] target_q;
    logic err_d;
    logic commit_d;
    always_comb begin
        seq_d = seq_q;
        err_d = 1'b0;
        commit_d = 1'b0;
        if (st_key) begin
            if (seq_q == fmwp_pkg::SEQ_IDLE && i_wr_data == fmwp_pkg::KEY_VALUE) begin
                seq_d = fmwp_pkg::SEQ_KEYED;
            end else begin
                err_d = 1'b1;
                seq_d = fmwp_pkg::SEQ_IDLE;
            end
        end else if (st_mode) begin
            case (seq_q)
                fmwp_pkg::SEQ_IDLE: begin
                    err_d = 1'b1;
                end
                fmwp_pkg::SEQ_KEYED: begin
                    seq_d = fmwp_pkg::SEQ_FIRST;
                end
                fmwp_pkg::SEQ_FIRST: begin
                    if (mode_wdata == ~target_q) begin
                        seq_d = fmwp_pkg::SEQ_INVERTED;
                    end else begin
                        err_d = 1'b1;
                        seq_d = fmwp_pkg::SEQ_IDLE;
                    end
                end
                fmwp_pkg::SEQ_INVERTED: begin
                    seq_d = fmwp_pkg::SEQ_IDLE;
                    if (mode_wdata == target_q &&
                        mode_wdata[1:0] != fmwp_pkg::SEL_PROHIBITED) begin
                        commit_d = 1'b1;
                    end else begin
                        err_d = 1'b1;
                    end
                end
                default: begin
                    seq_d = fmwp_pkg::SEQ_IDLE;
                end
            endcase
        end else if (st_other || st_status) begin
            if (seq_q != fmwp_pkg::SEQ_IDLE) begin
                err_d = 1'b1;
                seq_d = fmwp_pkg::SEQ_IDLE;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_q <= fmwp_pkg::SEQ_IDLE;
        end else begin
            seq_q <= seq_d;
        end
    end

    // target value captured from the second store
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            target_q <= 8'h00;
        end else if (st_mode && seq_q == fmwp_pkg::SEQ_KEYED) begin
            target_q <= mode_wdata;
        end
    end

    // ==========================================
    // mode control register; reset value follows the mode strap
    // the strap is only valid once it has crossed both sync stages,
    // so the reset value is loaded late and stores wait for it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            init_cnt_q <= 2'h0;
        end else if (!init_done) begin
            init_cnt_q <= init_cnt_q + 2'h1;
        end
    end

    always_comb begin
        mode_d = mode_q;
        if (!init_done) begin
            if (onboard) begin
                mode_d = fmwp_pkg::MODE_RESET_ONBOARD;
            end else begin
                mode_d = fmwp_pkg::MODE_RESET_USER;
            end
        end else if (commit_d) begin
            // pin level bit is not stored, it always reads the pin
            mode_d = 8'h00;
            mode_d[fmwp_pkg::BIT_WDIS] = mode_wdata[fmwp_pkg::BIT_WDIS];
            mode_d[fmwp_pkg::BIT_PIN] = mode_q[fmwp_pkg::BIT_PIN];
            mode_d[fmwp_pkg::BIT_SEL_HI] = mode_wdata[fmwp_pkg::BIT_SEL_HI];
            mode_d[fmwp_pkg::BIT_SEL_LO] = mode_wdata[fmwp_pkg::BIT_SEL_LO];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= fmwp_pkg::MODE_RESET_USER;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ==========================================
    // status register; a new error beats a clear in the same cycle
    // only bit 0 exists, the upper bits always read back as zero
    always_comb begin
        status_d = status_q;
        if (err_d) begin
            status_d[fmwp_pkg::BIT_ERR] = 1'b1;
        end else if (st_status && !status_wdata[fmwp_pkg::BIT_ERR]) begin
            status_d[fmwp_pkg::BIT_ERR] = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_q <= fmwp_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ==========================================
    // read port; key register reads as zero
    // loads have no side effects, so polling cannot disturb an unlock
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 8'h00;
        end else if (i_rd_en) begin
            case (i_rd_addr)
                fmwp_pkg::ADDR_MODE: o_rd_data <= mode_view;
                fmwp_pkg::ADDR_STATUS: o_rd_data <= status_q;
                default: o_rd_data <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // flash side outputs
    logic [1:0] eff_sel;
    logic [15:0] raw_addr;
    logic [15:0] flash_addr_d;
    always_comb begin
        eff_sel = onboard ? 2'h0 : mode_q[1:0];
        raw_addr = eff_sel[fmwp_pkg::BIT_SEL_HI] ? i_fw_addr : i_cpu_addr;
        flash_addr_d = raw_addr;
        // only the two lowest clusters trade places, the rest map straight
        if (o_boot_swap && raw_addr < fmwp_pkg::BOOT_AREA_END) begin
            flash_addr_d = raw_addr ^ (16'h0001 << fmwp_pkg::CLUSTER_BITS);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_boot_swap <= 1'b0;
        end else if (init_cnt_q == fmwp_pkg::INIT_CYCLES - 2'h1) begin
            // boot flag caught once per reset, so the swap holds until the next one
            o_boot_swap <= boot_sync_q[1];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flash_addr <= 16'h0000;
        end else begin
            o_flash_addr <= flash_addr_d;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_self_prog_mode <= 2'h0;
        end else begin
            o_self_prog_mode <= eff_sel;
        end
    end

    // write enable needs both the control bit and the pin, never one alone
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flash_write_enable <= 1'b0;
        end else begin
            o_flash_write_enable <= ~mode_q[fmwp_pkg::BIT_WDIS] & pin_level & init_done;
        end
    end
endmodule : fmwp_top

// [bench/fmwp_checker.sv]
// port assertions for fmwp_top
// assumes a bind onto fmwp_top, one clock domain
`timescale 1ns/1ns
module fmwp_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_wr_en,
    input wire logic i_wr_periph,
    input wire logic [15:0] i_wr_addr,
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_addr,
    input wire logic [7:0] o_rd_data,
    input wire logic i_flash_mode_pin,
    input wire logic [15:0] i_cpu_addr,
    input wire logic [15:0] i_fw_addr,
    input wire logic [15:0] o_flash_addr,
    input wire logic o_flash_write_enable,
    input wire logic [1:0] o_self_prog_mode,
    input wire logic o_boot_swap
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // helpers: cycles since reset, cycles since a mode store
    logic [3:0] up_q;
    logic [3:0] since_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) up_q <= 4'h0;
        else if (up_q != 4'hf) up_q <= up_q + 4'h1;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) since_q <= 4'hf;
        else if (i_wr_en && i_wr_periph && i_wr_addr == fmwp_pkg::ADDR_MODE) since_q <= 4'h0;
        else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
    function automatic logic [15:0] swp(input logic [15:0] a);
        return (o_boot_swap && a < fmwp_pkg::BOOT_AREA_END) ? a ^ 16'h1000 : a;
    endfunction : swp
    // ==========================================
    // assertions
    AST_SEL_LEGAL: assert property (o_self_prog_mode != fmwp_pkg::SEL_PROHIBITED)
        else $error("prohibited select on output");
    AST_ADDR_CPU: assert property (up_q > 4'h5 && !o_self_prog_mode[1]
        && $stable(o_self_prog_mode) |-> o_flash_addr == swp($past(i_cpu_addr)))
        else $error("flash address not from cpu");
    AST_ADDR_FW: assert property (up_q > 4'h5 && o_self_prog_mode[1]
        && $stable(o_self_prog_mode) |-> o_flash_addr == swp($past(i_fw_addr)))
        else $error("flash address not from firmware");
    AST_MODE_CHG: assert property ($changed(o_self_prog_mode) && up_q > 4'h5
        |-> since_q < 4'h4) else $error("mode changed without a mode store");
    AST_FWE: assert property (o_flash_write_enable |-> $past(i_flash_mode_pin, 3))
        else $error("write enabled with pin low");
    AST_KEY_RD: assert property (i_rd_en && i_rd_addr == fmwp_pkg::ADDR_KEY
        |=> o_rd_data == 8'h00) else $error("key register readable");
    AST_STAT_RD: assert property (i_rd_en && i_rd_addr == fmwp_pkg::ADDR_STATUS
        |=> o_rd_data[7:1] == 7'h00) else $error("status upper bits set");
    AST_MODE_RD: assert property (i_rd_en && i_rd_addr == fmwp_pkg::ADDR_MODE
        |=> o_rd_data[7:4] == 4'h0) else $error("mode upper bits set");
    AST_BOOT: assert property (up_q > 4'h5 |-> $stable(o_boot_swap))
        else $error("boot swap moved between resets");
    CV_FWE: cover property ($rose(o_flash_write_enable));
    CV_MODE: cover property ($changed(o_self_prog_mode) && up_q > 4'h5);
    CV_SWAP: cover property (o_boot_swap);
endmodule : fmwp_checker

// [bench/flash_mode_write_protect_tb_top.sv]
// directed bench for fmwp_top
// assumes ports driven here directly, checker bound below
`timescale 1ns/1ns
module flash_mode_write_protect_tb_top;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr_en = 1'b0, i_wr_periph = 1'b1;
    logic i_wr_bit = 1'b0, i_rd_en = 1'b0, i_flash_mode_pin = 1'b0;
    logic i_onboard_mode = 1'b0, i_boot_flag = 1'b0, o_flash_write_enable, o_boot_swap;
    logic [2:0] i_wr_bitpos = 3'h0;
    logic [7:0] i_wr_data = 8'h00, o_rd_data;
    logic [15:0] i_wr_addr = 16'h0000, i_rd_addr = 16'h0000, o_flash_addr;
    logic [15:0] i_cpu_addr = 16'h0123, i_fw_addr = 16'h3456;
    logic [1:0] o_self_prog_mode;
    int errors = 0, total_checks = 0;
    fmwp_top i_fmwp_top (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_wr_en(i_wr_en),
        .i_wr_periph(i_wr_periph),
        .i_wr_bit(i_wr_bit),
        .i_wr_bitpos(i_wr_bitpos),
        .i_wr_addr(i_wr_addr),
        .i_wr_data(i_wr_data),
        .i_rd_en(i_rd_en),
        .i_rd_addr(i_rd_addr),
        .o_rd_data(o_rd_data),
        .i_flash_mode_pin(i_flash_mode_pin),
        .i_onboard_mode(i_onboard_mode),
        .i_boot_flag(i_boot_flag),
        .i_cpu_addr(i_cpu_addr),
        .i_fw_addr(i_fw_addr),
        .o_flash_addr(o_flash_addr),
        .o_flash_write_enable(o_flash_write_enable),
        .o_self_prog_mode(o_self_prog_mode),
        .o_boot_swap(o_boot_swap)
    );
    always #25 i_sys_clk = ~i_sys_clk;
    // ==========================================
    // shared tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick;
        @(posedge i_sys_clk) #5;
    endtask : tick
    // back to back stores: strobe stays up between calls
    task automatic st(input logic [15:0] a, input logic [7:0] d, input logic p = 1'b1,
            input logic b = 1'b0);
        i_wr_en = 1'b1;
        i_wr_periph = p;
        i_wr_bit = b;
        i_wr_addr = a;
        i_wr_data = d;
        tick();
    endtask : st
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        i_wr_en = 1'b0;
        i_rd_en = 1'b1;
        i_rd_addr = a;
        tick();
        i_rd_en = 1'b0;
        cmp({8'h00, o_rd_data}, {8'h00, e});
        tick();
    endtask : rd
    task automatic unl(input logic [7:0] v);
        st(fmwp_pkg::ADDR_KEY, fmwp_pkg::KEY_VALUE);
        st(fmwp_pkg::ADDR_MODE, v);
        st(fmwp_pkg::ADDR_MODE, ~v);
        st(fmwp_pkg::ADDR_MODE, v);
    endtask : unl
    task automatic rst(input logic o, input logic f);
        i_rst_n = 1'b0;
        i_onboard_mode = o;
        i_boot_flag = f;
        repeat (16) tick();
        i_rst_n = 1'b1;
        repeat (4) tick();
    endtask : rst
    // ==========================================
    // scenarios
    task automatic t_reset;
        rd(fmwp_pkg::ADDR_MODE, fmwp_pkg::MODE_RESET_USER);
        rd(fmwp_pkg::ADDR_STATUS, fmwp_pkg::STATUS_RESET);
        rd(fmwp_pkg::ADDR_KEY, 8'h00);
        cmp({15'h0000, o_boot_swap}, 16'h0000);
        cmp({15'h0000, o_flash_write_enable}, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_unlock;
        i_flash_mode_pin = 1'b1;
        st(fmwp_pkg::ADDR_KEY, fmwp_pkg::KEY_VALUE);
        st(fmwp_pkg::ADDR_MODE, 8'h01);
        st(fmwp_pkg::ADDR_MODE, 8'h44, 1'b0);
        st(fmwp_pkg::ADDR_MODE, 8'hfe);
        rd(fmwp_pkg::ADDR_MODE, 8'h0c);
        st(fmwp_pkg::ADDR_MODE, 8'h01);
        rd(fmwp_pkg::ADDR_MODE, 8'h05);
        rd(fmwp_pkg::ADDR_STATUS, 8'h00);
        cmp({14'h0000, o_self_prog_mode}, 16'h0001);
        cmp({15'h0000, o_flash_write_enable}, 16'h0001);
        i_flash_mode_pin = 1'b0;
        repeat (4) tick();
        cmp({15'h0000, o_flash_write_enable}, 16'h0000);
        i_flash_mode_pin = 1'b1;
        repeat (4) tick();
        st(fmwp_pkg::ADDR_MODE, 8'h09);
        rd(fmwp_pkg::ADDR_MODE, 8'h05);
        rd(fmwp_pkg::ADDR_STATUS, 8'h01);
        st(fmwp_pkg::ADDR_STATUS, 8'h00, 1'b1, 1'b1);
        rd(fmwp_pkg::ADDR_STATUS, 8'h00);
        st(fmwp_pkg::ADDR_KEY, 8'h00);
        rd(fmwp_pkg::ADDR_STATUS, 8'h01);
        rd(fmwp_pkg::ADDR_STATUS, 8'h01);
        st(fmwp_pkg::ADDR_STATUS, 8'h00);
        i_wr_bitpos = 3'h5;
        st(fmwp_pkg::ADDR_STATUS, 8'h01, 1'b1, 1'b1);
        i_wr_bitpos = 3'h0;
        rd(fmwp_pkg::ADDR_STATUS, 8'h00);
        unl(8'h0b);
        rd(fmwp_pkg::ADDR_MODE, 8'h0f);
        cmp(o_flash_addr, i_fw_addr);
        cmp({15'h0000, o_flash_write_enable}, 16'h0000);
        unl(8'h08);
        rd(fmwp_pkg::ADDR_MODE, 8'h0c);
        cmp(o_flash_addr, i_cpu_addr);
        unl(8'h01);
        rd(fmwp_pkg::ADDR_MODE, 8'h05);
        $display("test unlock done");
    endtask : t_unlock
    task automatic t_errors;
        logic [23:0] tbl [6][5] = '{
            '{24'hffc0a5, 24'hffc409, 24'hffc200, 24'hff0000, 24'hff0000},
            '{24'hffc0a5, 24'hffc409, 24'hffc4f5, 24'hff0000, 24'hff0000},
            '{24'hffc0a5, 24'hffc409, 24'hffc4f6, 24'hffc40b, 24'hff0000},
            '{24'hffc0a5, 24'hffc40a, 24'hffc4f5, 24'hffc40a, 24'hff0000},
            '{24'hffc0a5, 24'hffc0a5, 24'hff0000, 24'hff0000, 24'hff0000},
            '{24'hffc0a5, 24'hffc409, 24'hffc200, 24'hffc4f6, 24'hffc409}};
        foreach (tbl[i]) begin
            foreach (tbl[i][j]) st(tbl[i][j][23:8], tbl[i][j][7:0]);
            rd(fmwp_pkg::ADDR_MODE, 8'h05);
            rd(fmwp_pkg::ADDR_STATUS, 8'h01);
            st(fmwp_pkg::ADDR_STATUS, 8'h00);
            rd(fmwp_pkg::ADDR_STATUS, 8'h00);
        end
        $display("test errors done");
    endtask : t_errors
    task automatic t_boot;
        logic [15:0] ad [4] = '{16'h0123, 16'h1234, 16'h2345, 16'h0084};
        rst(1'b1, 1'b1);
        rd(fmwp_pkg::ADDR_MODE, fmwp_pkg::MODE_RESET_ONBOARD);
        cmp({15'h0000, o_boot_swap}, 16'h0001);
        unl(8'h01);
        rd(fmwp_pkg::ADDR_STATUS, 8'h00);
        cmp({14'h0000, o_self_prog_mode}, 16'h0000);
        foreach (ad[i]) begin
            i_cpu_addr = ad[i];
            repeat (2) tick();
            cmp(o_flash_addr, ad[i] ^ ((ad[i] < 16'h2000) ? 16'h1000 : 16'h0000));
        end
        $display("test boot done");
    endtask : t_boot
    initial begin
        rst(1'b0, 1'b0);
        t_reset();
        t_unlock();
        t_errors();
        t_boot();
        close_out();
    end
    // hang guard
    initial begin
        #500000;
        errors++;
        close_out();
    end
endmodule : flash_mode_write_protect_tb_top
bind fmwp_top fmwp_checker i_fmwp_checker (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr_en(i_wr_en),
    .i_wr_periph(i_wr_periph),
    .i_wr_addr(i_wr_addr),
    .i_rd_en(i_rd_en),
    .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data),
    .i_flash_mode_pin(i_flash_mode_pin),
    .i_cpu_addr(i_cpu_addr),
    .i_fw_addr(i_fw_addr),
    .o_flash_addr(o_flash_addr),
    .o_flash_write_enable(o_flash_write_enable),
    .o_self_prog_mode(o_self_prog_mode),
    .o_boot_swap(o_boot_swap)
);
